// file: hdl/csx_cs_ctrl.sv
// Top of the chip-select shaping block: idle insertion and assert extension.
// Assumes a requester on aclk that holds req_valid until req_ack, and an AXI4-Lite master.
// Pins are registered; req_ack shows in the first cycle of the access it starts.
// Function
// (R1) Pair one/five: control bit set inserts one negated cycle between consecutive accesses.
// (R2) Pair zero/four: control bit set inserts one negated cycle between consecutive accesses.
// (R3) Write after read gets the larger of read-to-write field and consecutive idle.
// (R4) Extension bit set adds one chip-select cycle before and after the bus cycle.
// (R5) Extension bit clear adds no cycles around the bus cycle.
// (R6) Pair three/seven extension is bit 3, reset value 1.
// (R7) Pair two/six extension is bit 2, reset value 1.
// (R8) Pair one/five extension is bit 1, reset value 1.
// (R9) Pair zero/four extension is bit 0, reset value 1.
// (R10) Read-to-write field 00..11 gives zero to three idle cycles after pair zero/four.
// (R11) All control bits are read/write and apply from the next bus cycle.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module csx_cs_ctrl
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [3:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic req_valid,
	input wire csx_pkg::csx_req_t req,
	output logic req_ack,
	output csx_pkg::csx_pins_t pins
);
	import csx_pkg::*;

	typedef struct packed {
		csx_state_t st;
		csx_req_t cur;
		logic seen;
		logic ext;
		logic [1:0] idle_cnt;
		logic ack;
		csx_pins_t pins;
	} csx_seq_t;

	// Reset leaves every select and strobe negated
	localparam csx_pins_t PINS_IDLE = '{
		cs_n: 8'hFF,
		rd_n: 1'b1,
		wr_n: 4'hF
	};
	localparam csx_seq_t SEQ_RESET = '{
		st: CSX_IDLE,
		cur: '0,
		seen: 1'b0,
		ext: 1'b0,
		idle_cnt: 2'h0,
		ack: 1'b0,
		pins: PINS_IDLE
	};

	logic [15:0] ctrl;
	csx_stat_t stat;
	csx_seq_t s;
	csx_seq_t next_s;
	logic [1:0] need;
	logic [1:0] pair_need;
	logic [1:0] rtw_need;
	logic req_ext;
	logic go_now;

	// ****************************************
	// Register slave
	// ****************************************
	csx_axil_regs u_regs
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axil_awaddr),
		.awvalid(s_axil_awvalid),
		.awready(s_axil_awready),
		.wdata(s_axil_wdata),
		.wstrb(s_axil_wstrb),
		.wvalid(s_axil_wvalid),
		.wready(s_axil_wready),
		.bresp(s_axil_bresp),
		.bvalid(s_axil_bvalid),
		.bready(s_axil_bready),
		.araddr(s_axil_araddr),
		.arvalid(s_axil_arvalid),
		.arready(s_axil_arready),
		.rdata(s_axil_rdata),
		.rresp(s_axil_rresp),
		.rvalid(s_axil_rvalid),
		.rready(s_axil_rready),
		.stat(stat),
		.ctrl(ctrl)
	);

	assign stat = '{
		busy: !s.st[0],
		seen: s.seen,
		last_write: s.cur.write,
		last_space: s.cur.space,
		idle_cnt: s.idle_cnt
	};

	// ****************************************
	// Idle requirement against the previous access
	// ****************************************
	always_comb
	begin
		pair_need = 2'h0;
		rtw_need = 2'h0;
		// Same pair again: one negated cycle marks the end of the previous access
		if (s.seen && req.space[1:0] == s.cur.space[1:0])
		begin
			if (s.cur.space[1:0] == CSX_PAIR_ZERO && ctrl[CSX_IDLE_P0_BIT])
				pair_need = 2'h1; // R2
			if (s.cur.space[1:0] == CSX_PAIR_ONE && ctrl[CSX_IDLE_P1_BIT])
				pair_need = 2'h1; // R1
		end
		// Read of pair zero/four followed by a write or by another pair
		if (s.seen && !s.cur.write && s.cur.space[1:0] == CSX_PAIR_ZERO
			&& (req.write || req.space[1:0] != CSX_PAIR_ZERO))
			rtw_need = ctrl[CSX_RTW_LSB +: 2]; // R10
		// The larger demand wins; the two never add up
		if (rtw_need > pair_need)
			need = rtw_need; // R3
		else
			need = pair_need; // R3
		req_ext = ctrl[CSX_EXT_LSB + int'(req.space[1:0])]; // R6 R7 R8 R9
	end

	// ****************************************
	// Bus cycle sequencer
	// ****************************************
	always_comb
	begin
		next_s = s;
		next_s.ack = 1'b0;
		go_now = 1'b0;
		unique case (s.st)
			CSX_IDLE:
			begin
				// This cycle itself is already one negated cycle
				go_now = req_valid && ({1'b0, need} <= {1'b0, s.idle_cnt} + 3'h1);
				// Saturates at three, the longest gap any setting asks for
				if (!go_now && s.idle_cnt != 2'h3)
					next_s.idle_cnt = s.idle_cnt + 2'h1;
			end
			CSX_PRE:
				next_s.st = CSX_T1;
			CSX_T1:
				next_s.st = CSX_T2;
			CSX_T2:
			begin
				if (s.ext)
					next_s.st = CSX_POST; // R4
				else
				begin
					// Back to back only when no gap is owed; otherwise via IDLE
					go_now = req_valid && need == 2'h0; // R5
				end
			end
			CSX_POST:
				go_now = req_valid && need == 2'h0;
		endcase
		if (s.st[3] && !s.ext || s.st[4])
		begin
			next_s.st = CSX_IDLE;
			next_s.idle_cnt = 2'h0;
		end
		if (go_now)
		begin
			// Settings are latched here, so a write lands on the next bus cycle
			next_s.cur = req; // R11
			// Extension follows the pair of the new space, not the old one
			next_s.ext = req_ext;
			next_s.seen = 1'b1;
			next_s.ack = 1'b1;
			next_s.st = req_ext ? CSX_PRE : CSX_T1; // R4 R5
		end

		// ****************************************
		// Pin drive, registered from the next state
		// ****************************************
		next_s.pins = PINS_IDLE;
		if (!next_s.st[0])
			next_s.pins.cs_n = ~(8'h01 << next_s.cur.space);
		// Strobes only in T1/T2, so extension keeps them inside chip select
		if (next_s.st[2] || next_s.st[3])
		begin
			next_s.pins.rd_n = next_s.cur.write;
			next_s.pins.wr_n = next_s.cur.write ? ~next_s.cur.strb : 4'hF;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= SEQ_RESET;
		else
			s <= next_s;
	end

	// ****************************************
	// Outputs, straight from the state register
	// ****************************************
	assign req_ack = s.ack;
	assign pins = s.pins;

endmodule // csx_cs_ctrl

// file: hdl/csx_pkg.sv
// Shared constants, states and carriers of the chip-select idle and assert-extension block.
// Assumes one 40 MHz bus clock and a synchronous active-low reset.
package csx_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] CSX_OFS_CTRL = 4'h0;
	localparam logic [3:0] CSX_OFS_STAT = 4'h4;
	localparam logic [15:0] CSX_CTRL_RESET = 16'h033F;
	localparam logic [15:0] CSX_CTRL_MASK = 16'h033F;
	localparam int CSX_EXT_LSB = 0;
	localparam int CSX_IDLE_P0_BIT = 4;
	localparam int CSX_IDLE_P1_BIT = 5;
	localparam int CSX_RTW_LSB = 8;
	localparam logic [1:0] CSX_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSX_RESP_SLVERR = 2'h2;
	localparam logic [1:0] CSX_PAIR_ZERO = 2'h0;
	localparam logic [1:0] CSX_PAIR_ONE = 2'h1;

	// ****************************************
	// Sequencer states and carriers
	// ****************************************
	typedef enum logic [4:0] {
		CSX_IDLE = 5'b00001,
		CSX_PRE = 5'b00010,
		CSX_T1 = 5'b00100,
		CSX_T2 = 5'b01000,
		CSX_POST = 5'b10000
	} csx_state_t;

	typedef struct packed {
		logic [2:0] space;
		logic write;
		logic [3:0] strb;
	} csx_req_t;

	typedef struct packed {
		logic [7:0] cs_n;
		logic rd_n;
		logic [3:0] wr_n;
	} csx_pins_t;

	typedef struct packed {
		logic busy;
		logic seen;
		logic last_write;
		logic [2:0] last_space;
		logic [1:0] idle_cnt;
	} csx_stat_t;

endpackage

// file: hdl/csx_axil_regs.sv
// AXI4-Lite slave holding the control word and reading back sequencer status.
// Assumes a master on aclk that keeps at most one write and one read open.
`timescale 1ns/1ps
module csx_axil_regs
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire csx_pkg::csx_stat_t stat,
	output logic [15:0] ctrl
);
	import csx_pkg::*;

	typedef struct packed {
		logic aw_ok;
		logic [3:0] aw_addr;
		logic w_ok;
		logic [31:0] wd;
		logic [3:0] ws;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] ctrl;
	} csx_axs_t;

	localparam csx_axs_t AXS_RESET = '{aw_ok: 1'b0, aw_addr: 4'h0, w_ok: 1'b0, wd: 32'h0,
		ws: 4'h0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: CSX_RESP_OKAY,
		arready: 1'b1, rvalid: 1'b0, rdata: 32'h0, rresp: CSX_RESP_OKAY,
		ctrl: CSX_CTRL_RESET};

	csx_axs_t s;
	csx_axs_t next_s;

	always_comb
	begin
		next_s = s;
		if (awvalid && s.awready)
		begin
			next_s.aw_ok = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && s.wready)
		begin
			next_s.w_ok = 1'b1;
			next_s.wd = wdata;
			next_s.ws = wstrb;
		end
		// Response only once both halves are in
		if (s.aw_ok && s.w_ok && !s.bvalid)
		begin
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = CSX_RESP_OKAY;
			if (s.aw_addr == CSX_OFS_CTRL)
			begin
				if (s.ws[0])
					next_s.ctrl[7:0] = s.wd[7:0] & CSX_CTRL_MASK[7:0]; // R11
				if (s.ws[1])
					next_s.ctrl[15:8] = s.wd[15:8] & CSX_CTRL_MASK[15:8]; // R11
			end
			else if (s.aw_addr != CSX_OFS_STAT)
				next_s.bresp = CSX_RESP_SLVERR;
		end
		else if (s.bvalid && bready)
			next_s.bvalid = 1'b0;
		next_s.awready = !next_s.aw_ok && !next_s.bvalid;
		next_s.wready = !next_s.w_ok && !next_s.bvalid;
		if (arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = CSX_RESP_OKAY;
			next_s.rdata = 32'h0;
			if (araddr == CSX_OFS_CTRL)
				next_s.rdata[15:0] = s.ctrl; // R11
			else if (araddr == CSX_OFS_STAT)
				next_s.rdata[$bits(csx_stat_t)-1:0] = stat;
			else
				next_s.rresp = CSX_RESP_SLVERR;
		end
		else if (s.rvalid && rready)
			next_s.rvalid = 1'b0;
		next_s.arready = !next_s.rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= AXS_RESET;
		else
			s <= next_s;
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign ctrl = s.ctrl;

endmodule // csx_axil_regs

// file: verif/csx_cs_ctrl_asserts.sv
// Checker of strobe framing, request handshake and read channel.
// Assumes binding into csx_cs_ctrl, one clock, sync low reset.
`timescale 1ns/1ps
module csx_cs_ctrl_asserts
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req_valid,
	input wire logic req_ack,
	input wire csx_pkg::csx_pins_t pins,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic s_axil_arready
);
	import csx_pkg::*;
	// ****
	// Properties
	// ****
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_strb;
		!pins.rd_n || pins.wr_n != 4'hF;
	endsequence
	// Select low, no strobe yet: the leading extension cycle
	sequence s_pre;
		pins.cs_n != 8'hFF && $past(pins.cs_n) == 8'hFF && pins.rd_n && pins.wr_n == 4'hF;
	endsequence
	AST_RD_IN_CS: assert property (!pins.rd_n |-> pins.cs_n != 8'hFF)
		else $error("read strobe outside select");
	AST_WR_IN_CS: assert property (pins.wr_n != 4'hF |-> pins.cs_n != 8'hFF)
		else $error("write strobe outside select");
	AST_PRE_STRB: assert property (s_pre |=> s_strb)
		else $error("no strobe after lead cycle");
	AST_ACK_STRB: assert property (req_ack |-> ##[0:1] s_strb)
		else $error("strobe late after ack");
	AST_RD_TWO: assert property ($fell(pins.rd_n) |=> !pins.rd_n)
		else $error("read strobe too short");
	AST_ACK_REQ: assert property (req_ack |-> $past(req_valid) ##1 !req_ack)
		else $error("ack without request");
	AST_R_DONE: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
		else $error("read answer stays");
	AST_AR_HOLD: assert property (s_axil_rvalid |-> !s_axil_arready)
		else $error("read address open during answer");
endmodule // csx_cs_ctrl_asserts

bind csx_cs_ctrl csx_cs_ctrl_asserts csx_cs_ctrl_asserts_inst (.aclk, .aresetn, .req_valid,
	.req_ack, .pins, .s_axil_rvalid, .s_axil_rready, .s_axil_arready);

// file: verif/csx_mem_model.sv
// Memory on the chip selects; measures select runs and idle gaps.
// Assumes registered pins on aclk.
`timescale 1ns/1ps
module csx_mem_model
(
	input wire logic aclk,
	input wire csx_pkg::csx_pins_t pins,
	output logic [7:0] gap,
	output logic [7:0] run
);
	import csx_pkg::*;
	logic [7:0] idle_n = 8'h00;
	logic [7:0] low_n = 8'h00;
	logic [7:0] prev_n = 8'hFF;
	always_ff @(posedge aclk)
	begin
		prev_n <= pins.cs_n;
		if (pins.cs_n == 8'hFF)
			idle_n <= idle_n + 8'h01;
		else if (pins.cs_n != prev_n)
		begin
			// Space switch without idle counts as no gap
			gap <= (prev_n == 8'hFF) ? idle_n : 8'h00;
			idle_n <= 8'h00;
			low_n <= 8'h01;
		end
		else
			low_n <= low_n + 8'h01;
		if (prev_n != 8'hFF && pins.cs_n != prev_n)
			run <= low_n;
	end
endmodule // csx_mem_model

// file: verif/cs_idle_and_assert_extension_test.sv
// Bench: register tasks, access pairs, gap and run checks.
// Assumes the design package and the memory model.
`timescale 1ns/1ps
module cs_idle_and_assert_extension_test;
	import csx_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0, s_axil_wstrb = 4'hF;
	logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, q;
	logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
	logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0, req_valid = 1'h0;
	logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, req_ack;
	logic [1:0] s_axil_bresp, s_axil_rresp, r;
	logic [7:0] gap, run;
	csx_req_t req = '0;
	csx_pins_t pins;
	int mismatches = 0;
	int checks_done = 0;
	csx_cs_ctrl csx_cs_ctrl_inst (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
		.s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
		.s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
		.s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
		.req_valid, .req, .req_ack, .pins);
	csx_mem_model csx_mem_model_inst (.aclk, .pins, .gap, .run);
	initial
		forever #12.5 aclk = ~aclk;
	// ****
	// Tasks
	// ****
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang(input int n);
		if (n >= 40)
		begin
			mismatches++;
			wrap_up();
		end
	endtask
	// Handshakes judged at negedge, released at the taking edge
	task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tar, tb, tr;
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_araddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= w;
		s_axil_wvalid <= w;
		s_axil_bready <= w;
		s_axil_arvalid <= !w;
		s_axil_rready <= !w;
		for (n = 0; n < 40; n++)
		begin
			@(negedge aclk);
			ta = s_axil_awvalid & s_axil_awready;
			tw = s_axil_wvalid & s_axil_wready;
			tar = s_axil_arvalid & s_axil_arready;
			tb = s_axil_bready & s_axil_bvalid;
			tr = s_axil_rready & s_axil_rvalid;
			r = tb ? s_axil_bresp : s_axil_rresp;
			q = s_axil_rdata;
			@(posedge aclk);
			if (ta)
				s_axil_awvalid <= 1'h0;
			if (tw)
				s_axil_wvalid <= 1'h0;
			if (tar)
				s_axil_arvalid <= 1'h0;
			if (tb || tr)
			begin
				s_axil_bready <= 1'h0;
				s_axil_rready <= 1'h0;
				break;
			end
		end
		hang(n);
	endtask
	// Entered just after a rising edge; leaves request raised
	task automatic acc(input logic [2:0] s, input logic w);
		int n;
		req <= '{space: s, write: w, strb: 4'hF};
		req_valid <= 1'h1;
		for (n = 0; n < 40; n++)
		begin
			@(negedge aclk);
			if (req_ack === 1'h1)
				break;
			@(posedge aclk);
		end
		@(posedge aclk);
		hang(n);
	endtask
	task automatic pair(input logic [15:0] c, input logic [2:0] sa, input logic wa,
		input logic [2:0] sb, input logic wb, input logic [7:0] eg, input logic [7:0] er);
		int n;
		axi(1'h1, CSX_OFS_CTRL, {16'h0000, c});
		acc(sa, wa);
		acc(sb, wb);
		req_valid <= 1'h0;
		for (n = 0; n < 40 && pins.cs_n !== 8'hFF; n++)
			@(negedge aclk);
		hang(n);
		@(negedge aclk);
		chk(gap, eg);
		chk(run, er);
	endtask
	// ****
	// Sequence
	// ****
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		axi(1'h0, CSX_OFS_CTRL, 32'h0);
		chk(q, 32'h0000033F);
		axi(1'h1, 4'h8, 32'h0);
		chk(r, CSX_RESP_SLVERR);
		axi(1'h0, 4'h8, 32'h0);
		chk(r, CSX_RESP_SLVERR);
		axi(1'h1, CSX_OFS_CTRL, 32'hFFFF0000);
		chk(r, CSX_RESP_OKAY);
		axi(1'h0, CSX_OFS_CTRL, 32'h0);
		chk(q, 32'h00000000);
		pair(16'h033F, 3'h1, 1'h0, 3'h5, 1'h0, 8'h01, 8'h04);
		pair(16'h031F, 3'h1, 1'h0, 3'h5, 1'h0, 8'h00, 8'h04);
		pair(16'h033F, 3'h0, 1'h0, 3'h4, 1'h1, 8'h03, 8'h04);
		pair(16'h013F, 3'h0, 1'h0, 3'h0, 1'h1, 8'h01, 8'h04);
		pair(16'h022F, 3'h0, 1'h0, 3'h4, 1'h1, 8'h02, 8'h04);
		pair(16'h002F, 3'h0, 1'h0, 3'h4, 1'h1, 8'h00, 8'h04);
		pair(16'h003F, 3'h4, 1'h0, 3'h4, 1'h0, 8'h01, 8'h04);
		pair(16'h0330, 3'h2, 1'h0, 3'h6, 1'h1, 8'h00, 8'h02);
		pair(16'h0337, 3'h3, 1'h1, 3'h2, 1'h0, 8'h00, 8'h04);
		pair(16'h033F, 3'h3, 1'h0, 3'h7, 1'h1, 8'h00, 8'h04);
		pair(16'h0337, 3'h2, 1'h0, 3'h7, 1'h1, 8'h00, 8'h02);
		wrap_up();
	end
endmodule // cs_idle_and_assert_extension_test
